// File: bas_params.svh
// constants of the branch and arithmetic execution core
`ifndef BAS_PARAMS_SVH
`define BAS_PARAMS_SVH
// ---------------------------------------------------------------
// special function register and bit area byte addresses
// ---------------------------------------------------------------
`define BAS_SFR_SP 8'h81
`define BAS_SFR_DPL 8'h82
`define BAS_SFR_DPH 8'h83
`define BAS_SFR_PSW 8'hd0
`define BAS_SFR_ACC 8'he0
`define BAS_SFR_B 8'hf0
`define BAS_BIT_RAM_BASE 8'h20
// ---------------------------------------------------------------
// reset values and status word field positions
// ---------------------------------------------------------------
`define BAS_PC_RESET 16'h0000
`define BAS_SP_RESET 8'h07
`define BAS_PSW_RESET 8'h00
`define BAS_PSW_CY 7
`define BAS_PSW_AC 6
`define BAS_PSW_RS1 4
`define BAS_PSW_RS0 3
`define BAS_PSW_OV 2
// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define BAS_OP_NOP 8'h00
`define BAS_OP_LONG_JUMP 8'h02
`define BAS_OP_LONG_CALL 8'h12
`define BAS_OP_RRC 8'h13
`define BAS_OP_RET 8'h22
`define BAS_OP_INTERRUPT_RETURN 8'h32
`define BAS_OP_RLC 8'h33
`define BAS_OP_JZ 8'h60
`define BAS_OP_JNZ 8'h70
`define BAS_OP_MOV_A_IMM 8'h74
`define BAS_OP_MOV_D_IMM 8'h75
`define BAS_OP_SHORT_RELATIVE_JUMP 8'h80
`define BAS_OP_DIV 8'h84
`define BAS_OP_MOV_DPTR 8'h90
`define BAS_OP_MUL 8'ha4
`define BAS_OP_CLR_BIT 8'hc2
`define BAS_OP_SETB_BIT 8'hd2
`define BAS_OP_DECREMENT_AND_BRANCH_D 8'hd5
`define BAS_OP_MOV_A_D 8'he5
`define BAS_OP_MOV_D_A 8'hf5
`define BAS_ABS_JMP 5'h01
`define BAS_ABS_CALL 5'h11
`define BAS_HI_ADD 4'h2
`define BAS_HI_ADD_WITH_CARRY 4'h3
`define BAS_HI_SUBTRACT_WITH_BORROW 4'h9
`define BAS_HI_COMPARE_AND_BRANCH 4'hb
`define BAS_HI_DECREMENT_AND_BRANCH_R 5'h1b
`endif

// File: bas_pkg.sv
// types of the branch and arithmetic execution core
package bas_pkg;
  typedef enum {S_FETCH, S_OPCODE, S_BYTE1, S_BYTE2, S_EXEC, S_PUSH_HI} bas_state_type;
  typedef enum {ALU_PASS, ALU_ADD, ALU_ADD_WITH_CARRY, ALU_SUBTRACT_WITH_BORROW, ALU_MUL, ALU_DIV, ALU_RRC,
    ALU_RLC, ALU_DEC, ALU_CMP} bas_aluop_type;
endpackage : bas_pkg

// File: bas_alu_if.sv
// operand and flag bundle between the core and its arithmetic unit
`timescale 1ns/1ps
interface bas_alu_if;
  import bas_pkg::*;
  bas_aluop_type op;
  logic [7:0] a;
  logic [7:0] b;
  logic cy_in;
  logic [7:0] res;
  logic [7:0] res_b;
  logic cy;
  logic ov;
  logic ac;
  logic upd_cy;
  logic upd_ov;
  logic upd_ac;
  modport core (output op, a, b, cy_in, input res, res_b, cy, ov, ac, upd_cy, upd_ov, upd_ac);
  modport alu (input op, a, b, cy_in, output res, res_b, cy, ov, ac, upd_cy, upd_ov, upd_ac);
endinterface : bas_alu_if

// File: bas_alu.sv
// arithmetic unit with carry, overflow and auxiliary carry results
`timescale 1ns/1ps
module bas_alu (
  bas_alu_if.alu bus
);
  import bas_pkg::*;
  logic [8:0] wide;
  logic [4:0] nib;
  logic [15:0] prod;

  // result and flag computation
  always_comb begin
    wide = 9'h000;
    nib = 5'h00;
    prod = {8'h00, bus.a} * {8'h00, bus.b};
    bus.res = bus.a;
    bus.res_b = bus.b;
    bus.cy = 1'b0;
    bus.ov = 1'b0;
    bus.ac = 1'b0;
    bus.upd_cy = 1'b0;
    bus.upd_ov = 1'b0;
    bus.upd_ac = 1'b0;
    unique case (bus.op)
      ALU_ADD, ALU_ADD_WITH_CARRY: begin
        wide = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.op == ALU_ADD_WITH_CARRY && bus.cy_in};
        nib = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.op == ALU_ADD_WITH_CARRY && bus.cy_in};
        bus.res = wide[7:0];
        bus.cy = wide[8];
        bus.ac = nib[4];
        bus.ov = (bus.a[7] == bus.b[7]) && (wide[7] != bus.a[7]);
        {bus.upd_cy, bus.upd_ov, bus.upd_ac} = 3'b111;
      end
      ALU_SUBTRACT_WITH_BORROW: begin
        wide = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cy_in};
        nib = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, bus.cy_in};
        bus.res = wide[7:0];
        bus.cy = wide[8];
        bus.ac = nib[4];
        bus.ov = (bus.a[7] != bus.b[7]) && (wide[7] != bus.a[7]);
        {bus.upd_cy, bus.upd_ov, bus.upd_ac} = 3'b111;
      end
      ALU_MUL: begin
        bus.res = prod[7:0];
        bus.res_b = prod[15:8];
        bus.ov = |prod[15:8];
        {bus.upd_cy, bus.upd_ov} = 2'b11;
      end
      ALU_DIV: begin
        if (bus.b != 8'h00) begin
          bus.res = bus.a / bus.b;
          bus.res_b = bus.a % bus.b;
        end
        bus.ov = bus.b == 8'h00; // divide by zero leaves operands
        {bus.upd_cy, bus.upd_ov} = 2'b11;
      end
      ALU_RRC: begin
        bus.res = {bus.cy_in, bus.a[7:1]};
        bus.cy = bus.a[0];
        bus.upd_cy = 1'b1;
      end
      ALU_RLC: begin
        bus.res = {bus.a[6:0], bus.cy_in};
        bus.cy = bus.a[7];
        bus.upd_cy = 1'b1;
      end
      ALU_DEC: bus.res = bus.a - 8'h01;
      ALU_CMP: begin
        bus.cy = bus.a < bus.b;
        bus.upd_cy = 1'b1;
      end
      ALU_PASS: bus.res = bus.a;
    endcase
  end
endmodule : bas_alu

// File: bas_core.sv
// branch and arithmetic execution core of the 8-bit accumulator machine
`timescale 1ns/1ps
`include "bas_params.svh"
// ---------------------------------------------------------------
// Overview of operation
// - return resumes after the entering call
// - interrupt return also signals service done
// - interrupt return outside service equals return
// - signed 8-bit offset from next instruction
// - zero jumps test accumulator, no zero flag
// - decrement operand, branch when result nonzero
// - compare operands, branch only when different
// - unsigned compare sets carry when first smaller
// - arithmetic ops update their documented flags
// - status word writes change flags directly
// - working register picks one of eight in bank
// - direct below 128 RAM, above special registers
// - indirect through index register 0 or 1
// - immediates are 8 bits, long form 16
// - long jump and call reach 64K space
// - absolute target stays in 2K page
// - bit operand addresses RAM or special register bit
// - absolute form replaces low 11 PC bits
// ---------------------------------------------------------------
module bas_core #(
  parameter int IRAM_WORDS = 256
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [7:0] PM_DATA,
  input wire logic INT_IN_SERVICE,
  output logic [15:0] PM_ADDR,
  output logic PM_RD,
  output logic INT_DONE,
  output logic [7:0] ACC_OUT,
  output logic [7:0] STATUS_OUT
);
  import bas_pkg::*;
  bas_state_type state_reg, state_next;
  logic [15:0] pc_reg, pc_next, dptr_reg, dptr_next;
  logic [7:0] op_reg, op_next, b1_reg, b1_next, b2_reg, b2_next;
  logic [7:0] acc_reg, acc_next, b_reg, b_next, psw_reg, psw_next, sp_reg, sp_next;
  logic done_reg, done_next;
  logic [7:0] iram [IRAM_WORDS];
  logic ram_we;
  logic [7:0] ram_addr, ram_data;
  logic dir_we;
  logic [7:0] dir_addr, dir_data;
  bas_alu_if alu_bus ();

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    if (op == `BAS_OP_LONG_JUMP || op == `BAS_OP_LONG_CALL || op == `BAS_OP_MOV_D_IMM ||
        op == `BAS_OP_MOV_DPTR || op == `BAS_OP_DECREMENT_AND_BRANCH_D ||
        (op[7:4] == `BAS_HI_COMPARE_AND_BRANCH && op[3:0] >= 4'h4))
      return 2'd3;
    if (op == `BAS_OP_SHORT_RELATIVE_JUMP || op == `BAS_OP_JZ || op == `BAS_OP_JNZ ||
        op == `BAS_OP_MOV_A_IMM || op == `BAS_OP_MOV_A_D || op == `BAS_OP_MOV_D_A ||
        op == `BAS_OP_SETB_BIT || op == `BAS_OP_CLR_BIT || op[7:3] == `BAS_HI_DECREMENT_AND_BRANCH_R ||
        op[4:0] == `BAS_ABS_JMP || op[4:0] == `BAS_ABS_CALL ||
        ((op[7:4] == `BAS_HI_ADD || op[7:4] == `BAS_HI_ADD_WITH_CARRY || op[7:4] == `BAS_HI_SUBTRACT_WITH_BORROW) &&
         (op[3:0] == 4'h4 || op[3:0] == 4'h5)))
      return 2'd2;
    return 2'd1;
  endfunction : instr_len

  // direct byte read: low half RAM, high half special registers
  function automatic logic [7:0] rd_direct(input logic [7:0] addr);
    if (!addr[7])
      return iram[addr];
    unique case (addr)
      `BAS_SFR_SP: return sp_reg;
      `BAS_SFR_DPL: return dptr_reg[7:0];
      `BAS_SFR_DPH: return dptr_reg[15:8];
      `BAS_SFR_PSW: return psw_reg;
      `BAS_SFR_ACC: return acc_reg;
      `BAS_SFR_B: return b_reg;
      default: return 8'h00;
    endcase
  endfunction : rd_direct

  function automatic logic [15:0] sext(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction : sext

  // ---------------------------------------------------------------
  // instruction classes and operands
  // ---------------------------------------------------------------
  logic [3:0] lo;
  logic ex, is_ret, is_interrupt_return, is_call, is_abs, is_long, is_decrement_and_branch, is_compare_and_branch, is_arith, is_bit;
  logic [7:0] reg_addr, ind_addr, src_val, decrement_and_branch_val, cmp_a, cmp_b, rel, bit_byte, bit_new;
  logic [15:0] ret_addr, rel_target, abs_target, long_target, call_target;

  assign lo = op_reg[3:0];
  assign ex = state_reg == S_EXEC;
  assign is_ret = op_reg == `BAS_OP_RET || op_reg == `BAS_OP_INTERRUPT_RETURN;
  assign is_interrupt_return = op_reg == `BAS_OP_INTERRUPT_RETURN;
  assign is_abs = op_reg[4:0] == `BAS_ABS_JMP || op_reg[4:0] == `BAS_ABS_CALL;
  assign is_long = op_reg == `BAS_OP_LONG_JUMP || op_reg == `BAS_OP_LONG_CALL;
  assign is_call = op_reg == `BAS_OP_LONG_CALL || op_reg[4:0] == `BAS_ABS_CALL;
  assign is_decrement_and_branch = op_reg == `BAS_OP_DECREMENT_AND_BRANCH_D || op_reg[7:3] == `BAS_HI_DECREMENT_AND_BRANCH_R;
  assign is_compare_and_branch = op_reg[7:4] == `BAS_HI_COMPARE_AND_BRANCH && lo >= 4'h4;
  assign is_arith = (op_reg[7:4] == `BAS_HI_ADD || op_reg[7:4] == `BAS_HI_ADD_WITH_CARRY ||
                     op_reg[7:4] == `BAS_HI_SUBTRACT_WITH_BORROW) && lo >= 4'h4;
  assign is_bit = op_reg == `BAS_OP_SETB_BIT || op_reg == `BAS_OP_CLR_BIT;
  // bank select from status word, eight registers per bank
  assign reg_addr = {3'b000, psw_reg[`BAS_PSW_RS1:`BAS_PSW_RS0], op_reg[2:0]};
  assign ind_addr = iram[{3'b000, psw_reg[`BAS_PSW_RS1:`BAS_PSW_RS0], 2'b00, op_reg[0]}];
  assign src_val = lo == 4'h4 ? b1_reg : lo == 4'h5 ? rd_direct(b1_reg) :
                   lo[3] ? iram[reg_addr] : iram[ind_addr];
  assign decrement_and_branch_val = op_reg == `BAS_OP_DECREMENT_AND_BRANCH_D ? rd_direct(b1_reg) : iram[reg_addr];
  assign cmp_a = lo[3] ? iram[reg_addr] : lo[3:1] == 3'b011 ? iram[ind_addr] : acc_reg;
  assign cmp_b = lo == 4'h5 ? rd_direct(b1_reg) : b1_reg;
  assign rel = (op_reg[7:3] == `BAS_HI_DECREMENT_AND_BRANCH_R || op_reg == `BAS_OP_SHORT_RELATIVE_JUMP ||
                op_reg == `BAS_OP_JZ || op_reg == `BAS_OP_JNZ) ? b1_reg : b2_reg;
  // pc already points past the whole instruction here
  assign rel_target = pc_reg + sext(rel);
  assign abs_target = {pc_reg[15:11], op_reg[7:5], b1_reg};
  assign long_target = {b1_reg, b2_reg};
  assign call_target = is_long ? long_target : abs_target;
  assign ret_addr = {iram[sp_reg], iram[sp_reg - 8'h01]};
  // bit address: low half maps to RAM bit area, high half to special registers
  assign bit_byte = b1_reg[7] ? {b1_reg[7:3], 3'b000} :
                    `BAS_BIT_RAM_BASE + {4'h0, b1_reg[6:3]};
  always_comb begin
    bit_new = rd_direct(bit_byte);
    bit_new[b1_reg[2:0]] = op_reg == `BAS_OP_SETB_BIT;
  end

  // ---------------------------------------------------------------
  // arithmetic unit
  // ---------------------------------------------------------------
  always_comb begin
    alu_bus.op = ALU_PASS;
    alu_bus.a = acc_reg;
    alu_bus.b = src_val;
    alu_bus.cy_in = psw_reg[`BAS_PSW_CY];
    if (is_arith)
      alu_bus.op = op_reg[7:4] == `BAS_HI_ADD ? ALU_ADD :
                   op_reg[7:4] == `BAS_HI_ADD_WITH_CARRY ? ALU_ADD_WITH_CARRY : ALU_SUBTRACT_WITH_BORROW;
    else if (op_reg == `BAS_OP_MUL || op_reg == `BAS_OP_DIV) begin
      alu_bus.op = op_reg == `BAS_OP_MUL ? ALU_MUL : ALU_DIV;
      alu_bus.b = b_reg;
    end else if (op_reg == `BAS_OP_RRC)
      alu_bus.op = ALU_RRC;
    else if (op_reg == `BAS_OP_RLC)
      alu_bus.op = ALU_RLC;
    else if (is_decrement_and_branch) begin
      alu_bus.op = ALU_DEC;
      alu_bus.a = decrement_and_branch_val;
    end else if (is_compare_and_branch) begin
      alu_bus.op = ALU_CMP;
      alu_bus.a = cmp_a;
      alu_bus.b = cmp_b;
    end
  end

  bas_alu u_alu (
    .bus(alu_bus)
  );

  // ---------------------------------------------------------------
  // fetch and execute sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    op_next = op_reg;
    b1_next = b1_reg;
    b2_next = b2_reg;
    acc_next = acc_reg;
    b_next = b_reg;
    psw_next = psw_reg;
    sp_next = sp_reg;
    dptr_next = dptr_reg;
    done_next = 1'b0;
    ram_we = 1'b0;
    ram_addr = 8'h00;
    ram_data = 8'h00;
    dir_we = 1'b0;
    dir_addr = 8'h00;
    dir_data = 8'h00;
    PM_RD = 1'b0;
    unique case (state_reg)
      S_FETCH: begin
        PM_RD = 1'b1;
        pc_next = pc_reg + 16'h0001;
        state_next = S_OPCODE;
      end
      S_OPCODE: begin
        op_next = PM_DATA;
        state_next = S_EXEC;
        if (instr_len(PM_DATA) != 2'd1) begin
          PM_RD = 1'b1;
          pc_next = pc_reg + 16'h0001;
          state_next = S_BYTE1;
        end
      end
      S_BYTE1: begin
        b1_next = PM_DATA;
        state_next = S_EXEC;
        if (instr_len(op_reg) == 2'd3) begin
          PM_RD = 1'b1;
          pc_next = pc_reg + 16'h0001;
          state_next = S_BYTE2;
        end
      end
      S_BYTE2: begin
        b2_next = PM_DATA;
        state_next = S_EXEC;
      end
      S_EXEC: begin
        state_next = S_FETCH;
        // flags from the arithmetic unit
        if (alu_bus.upd_cy) psw_next[`BAS_PSW_CY] = alu_bus.cy;
        if (alu_bus.upd_ov) psw_next[`BAS_PSW_OV] = alu_bus.ov;
        if (alu_bus.upd_ac) psw_next[`BAS_PSW_AC] = alu_bus.ac;
        if (is_arith || op_reg == `BAS_OP_RRC || op_reg == `BAS_OP_RLC)
          acc_next = alu_bus.res;
        if (op_reg == `BAS_OP_MUL || op_reg == `BAS_OP_DIV) begin
          acc_next = alu_bus.res;
          b_next = alu_bus.res_b;
        end
        if (is_ret) begin
          pc_next = ret_addr;
          sp_next = sp_reg - 8'h02;
          done_next = is_interrupt_return && INT_IN_SERVICE;
        end
        if (is_call) begin
          // return address low byte first, high byte next cycle
          ram_we = 1'b1;
          ram_addr = sp_reg + 8'h01;
          ram_data = pc_reg[7:0];
          sp_next = sp_reg + 8'h01;
          state_next = S_PUSH_HI;
        end else if (is_abs)
          pc_next = abs_target;
        if (op_reg == `BAS_OP_LONG_JUMP)
          pc_next = long_target;
        if (op_reg == `BAS_OP_SHORT_RELATIVE_JUMP ||
            (op_reg == `BAS_OP_JZ && acc_reg == 8'h00) ||
            (op_reg == `BAS_OP_JNZ && acc_reg != 8'h00) ||
            (is_decrement_and_branch && alu_bus.res != 8'h00) ||
            (is_compare_and_branch && cmp_a != cmp_b))
          pc_next = rel_target;
        if (is_decrement_and_branch && op_reg == `BAS_OP_DECREMENT_AND_BRANCH_D) begin
          dir_we = 1'b1;
          dir_addr = b1_reg;
          dir_data = alu_bus.res;
        end else if (is_decrement_and_branch) begin
          ram_we = 1'b1;
          ram_addr = reg_addr;
          ram_data = alu_bus.res;
        end
        if (op_reg == `BAS_OP_MOV_A_IMM) acc_next = b1_reg;
        if (op_reg == `BAS_OP_MOV_A_D) acc_next = rd_direct(b1_reg);
        if (op_reg == `BAS_OP_MOV_DPTR) dptr_next = {b1_reg, b2_reg};
        if (op_reg == `BAS_OP_MOV_D_IMM || op_reg == `BAS_OP_MOV_D_A) begin
          dir_we = 1'b1;
          dir_addr = b1_reg;
          dir_data = op_reg == `BAS_OP_MOV_D_A ? acc_reg : b2_reg;
        end
        if (is_bit) begin
          dir_we = 1'b1;
          dir_addr = bit_byte;
          dir_data = bit_new;
        end
      end
      S_PUSH_HI: begin
        ram_we = 1'b1;
        ram_addr = sp_reg + 8'h01;
        ram_data = pc_reg[15:8];
        sp_next = sp_reg + 8'h01;
        pc_next = call_target;
        state_next = S_FETCH;
      end
    endcase
    // direct writes: RAM below 128, special registers above
    if (dir_we) begin
      if (!dir_addr[7]) begin
        ram_we = 1'b1;
        ram_addr = dir_addr;
        ram_data = dir_data;
      end else begin
        unique case (dir_addr)
          `BAS_SFR_SP: sp_next = dir_data;
          `BAS_SFR_DPL: dptr_next[7:0] = dir_data;
          `BAS_SFR_DPH: dptr_next[15:8] = dir_data;
          `BAS_SFR_PSW: psw_next = dir_data;
          `BAS_SFR_ACC: acc_next = dir_data;
          `BAS_SFR_B: b_next = dir_data;
          default: ;
        endcase
      end
    end
  end

  // state registers and internal RAM
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_reg <= S_FETCH;
      pc_reg <= `BAS_PC_RESET;
      op_reg <= `BAS_OP_NOP;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      acc_reg <= 8'h00;
      b_reg <= 8'h00;
      psw_reg <= `BAS_PSW_RESET;
      sp_reg <= `BAS_SP_RESET;
      dptr_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      op_reg <= op_next;
      b1_reg <= b1_next;
      b2_reg <= b2_next;
      acc_reg <= acc_next;
      b_reg <= b_next;
      psw_reg <= psw_next;
      sp_reg <= sp_next;
      dptr_reg <= dptr_next;
      done_reg <= done_next;
    end
    if (ram_we && !RESET)
      iram[ram_addr] <= ram_data;
  end

  assign PM_ADDR = pc_reg;
  assign INT_DONE = done_reg;
  assign ACC_OUT = acc_reg;
  assign STATUS_OUT = psw_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  ret_resume_a: assert property (ex && op_reg == `BAS_OP_RET |=> pc_reg == $past(ret_addr))
    else $error("return address wrong");
  interrupt_return_notify_a: assert property (ex && is_interrupt_return && INT_IN_SERVICE |=> INT_DONE ##1 !INT_DONE)
    else $error("interrupt return not signalled");
  interrupt_return_idle_a: assert property (ex && is_interrupt_return && !INT_IN_SERVICE |=> !INT_DONE && pc_reg == $past(ret_addr))
    else $error("idle interrupt return differs from return");
  rel_target_a: assert property (ex && op_reg == `BAS_OP_SHORT_RELATIVE_JUMP |=> pc_reg == $past(pc_reg) + sext($past(b1_reg)))
    else $error("relative target wrong");
  acc_zero_a: assert property (ex && op_reg == `BAS_OP_JZ && acc_reg != 8'h00 |=> pc_reg == $past(pc_reg))
    else $error("zero jump taken on nonzero");
  decrement_and_branch_exit_a: assert property (ex && is_decrement_and_branch && decrement_and_branch_val == 8'h01 |=> pc_reg == $past(pc_reg))
    else $error("loop branch on zero result");
  compare_and_branch_equal_a: assert property (ex && is_compare_and_branch |=> (pc_reg == $past(pc_reg)) == $past(cmp_a == cmp_b || rel == 8'h00))
    else $error("compare branch wrong");
  compare_and_branch_carry_a: assert property (ex && is_compare_and_branch |=> psw_reg[`BAS_PSW_CY] == $past(cmp_a < cmp_b))
    else $error("compare carry wrong");
  mul_flags_a: assert property (ex && op_reg == `BAS_OP_MUL |=> !psw_reg[`BAS_PSW_CY])
    else $error("multiply left carry set");
  psw_write_a: assert property (ex && op_reg == `BAS_OP_MOV_D_IMM && b1_reg == `BAS_SFR_PSW |=> psw_reg == $past(b2_reg))
    else $error("status word write lost");
  abs_page_a: assert property (ex && op_reg[4:0] == `BAS_ABS_JMP |=> pc_reg == {$past(pc_reg[15:11]), $past(op_reg[7:5]), $past(b1_reg)})
    else $error("absolute target wrong");
  call_target_a: assert property (ex && op_reg == `BAS_OP_LONG_CALL |=> ##1 pc_reg == $past(long_target, 2))
    else $error("long call target wrong");
  interrupt_return_cover_c: cover property (ex && is_interrupt_return && INT_IN_SERVICE);
  decrement_and_branch_loop_c: cover property (ex && is_decrement_and_branch && decrement_and_branch_val != 8'h01);
  call_ret_c: cover property (ex && is_call ##[1:40] ex && is_ret);
endmodule : bas_core

// File: bas_pm_model.sv
// program memory model answering the core one byte per read strobe
`timescale 1ns/1ps
module bas_pm_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic [15:0] addr,
  output logic [7:0] data
);
  logic [7:0] mem [0:65535];
  initial data = 8'h00;
  // byte appears one cycle after the strobe; between reads the lines keep toggling
  always @(posedge clk) begin
    if (rd === 1'b1) begin
      data <= mem[addr];
    end else begin
      data <= ~data;
    end
  end
endmodule : bas_pm_model

// File: tb.sv
// self-checking bench for the branch and arithmetic core
`timescale 1ns/1ps
`include "bas_params.svh"
module tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic int_in_service = 1'b0;
  logic [7:0] pm_data;
  logic [15:0] pm_addr;
  logic pm_rd;
  logic int_done;
  logic [7:0] acc_out;
  logic [7:0] status_out;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_done = 0;
  logic [7:0] a, b, v, pv;
  logic [10:0] t;
  logic [15:0] p, x;
  logic [3:0] ops [3] = '{`BAS_HI_ADD, `BAS_HI_ADD_WITH_CARRY, `BAS_HI_SUBTRACT_WITH_BORROW};

  always #12.5 sys_clk = ~sys_clk;

  bas_core u_bas_core (.SYS_CLK(sys_clk), .RESET(reset), .PM_DATA(pm_data),
    .INT_IN_SERVICE(int_in_service), .PM_ADDR(pm_addr), .PM_RD(pm_rd),
    .INT_DONE(int_done), .ACC_OUT(acc_out), .STATUS_OUT(status_out));
  bas_pm_model u_bas_pm_model (.clk(sys_clk), .rd(pm_rd), .addr(pm_addr), .data(pm_data));

  // cycle ceiling and count of service done pulses
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (int_done === 1'b1) n_done <= n_done + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic put(input logic [15:0] at, input logic [7:0] q[$]);
    foreach (q[j]) u_bas_pm_model.mem[at + j] = q[j];
  endtask : put

  task automatic prep(input logic [7:0] q[$]);
    u_bas_pm_model.mem = '{default: 8'h00};
    put(16'h0000, q);
  endtask : prep

  // reset, then run until the halt loop is fetched
  task automatic run(input logic [15:0] halt, input logic svc);
    int k;
    @(posedge sys_clk);
    reset <= 1'b1;
    int_in_service <= svc;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    for (k = 0; k < 600; k++) begin
      @(negedge sys_clk);
      if (pm_rd === 1'b1 && pm_addr === halt) break;
    end
    check("halt reached", 16'(k < 600), 16'h0001);
    repeat (2) @(negedge sys_clk);
  endtask : run

  // expected {carry, aux carry, overflow, result}
  function automatic logic [10:0] arith(int op, logic [7:0] u, logic [7:0] w, logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic ov;
    if (op == 2) begin
      s = {1'b0, u} - {1'b0, w} - 9'(c);
      h = {1'b0, u[3:0]} - {1'b0, w[3:0]} - 5'(c);
      ov = (u[7] != w[7]) && (s[7] != u[7]);
    end else begin
      s = {1'b0, u} + {1'b0, w} + 9'(c & (op == 1));
      h = {1'b0, u[3:0]} + {1'b0, w[3:0]} + 5'(c & (op == 1));
      ov = (u[7] == w[7]) && (s[7] != u[7]);
    end
    return {s[8], h[4], ov, s[7:0]};
  endfunction : arith

  // main sequence: random programs with corner values first
  initial begin
    void'($urandom(32'h5bf64ea5));
    for (int i = 0; i < 20; i++) begin
      v = (i < 4) ? 8'h00 : 8'($urandom);
      prep('{8'h74, v, (i[0] ? `BAS_OP_JNZ : `BAS_OP_JZ), 8'h02, 8'h74, 8'h11, 8'h80, 8'hfe});
      run(16'h0006, 1'b0);
      check("acc zero jump", acc_out, (i[0] ^ (v == 8'h00)) ? v : 8'h11);
      a = 8'($urandom);
      b = (i < 3) ? a : 8'($urandom);
      prep('{8'h74, a, {`BAS_HI_COMPARE_AND_BRANCH, 4'h4}, b, 8'h02, 8'h74, 8'h55, 8'h80, 8'hfe});
      run(16'h0007, 1'b0);
      check("acc compare", acc_out, (a != b) ? a : 8'h55);
      check("carry compare", status_out[7], a < b);
      v = (i == 0) ? 8'h01 : 8'(1 + $urandom % 16);
      prep('{8'h74, 8'h00, 8'h75, 8'h30, v, 8'h24, 8'h01, `BAS_OP_DECREMENT_AND_BRANCH_D, 8'h30, 8'hfb,
        8'h80, 8'hfe});
      run(16'h000a, 1'b0);
      check("acc loop", acc_out, v);
      a = (i == 0) ? 8'h7f : 8'($urandom);
      b = (i == 0) ? 8'h01 : 8'($urandom);
      pv = {1'($urandom), 2'b00, 2'($urandom), 3'b000};
      prep('{8'h75, 8'hd0, pv, 8'h74, a, {ops[i % 3], 4'h4}, b, 8'h80, 8'hfe});
      run(16'h0007, 1'b0);
      x = 16'(arith(i % 3, a, b, pv[7]));
      check("acc arith", acc_out, x[7:0]);
      check("status arith", status_out & 8'hdc, {x[10:9], 1'b0, pv[4:3], x[8], 2'b00});
      // bank register, indirect through index 0 and a set bit in the bit area
      pv = {3'b000, 2'($urandom), 3'b000};
      t = 11'($urandom % 8);
      x = 16'(arith(0, 8'h01 << t[2:0], a, 1'b0));
      x = 16'(arith(1, x[7:0], b, x[10]));
      prep('{8'h75, 8'hd0, pv, 8'h75, pv, 8'h40, 8'h75, 8'h40, a, 8'h75, pv | 8'h05, b,
        8'h75, 8'h20, 8'h00, `BAS_OP_SETB_BIT, {5'h00, t[2:0]}, 8'he5, 8'h20, 8'h26, 8'h3d,
        8'h80, 8'hfe});
      run(16'h0015, 1'b0);
      check("acc operand", acc_out, x[7:0]);
      x = {1'b1, 15'($urandom)} & 16'hfffc;
      prep('{`BAS_OP_LONG_CALL, x[15:8], x[7:0], 8'h74, 8'h66, 8'h80, 8'hfe});
      put(x, '{8'h74, 8'h77, (i[1] ? `BAS_OP_INTERRUPT_RETURN : `BAS_OP_RET)});
      v = 8'(n_done);
      run(16'h0005, i[0]);
      pv = 8'(n_done) - v;
      check("acc return", acc_out, 8'h66);
      check("done pulses", pv, 8'(i[0] & i[1]));
      p = {5'(1 + $urandom % 30), 11'h7fe};
      t = 11'h100 + 11'($urandom % 512);
      x = {p[15:11] + 5'h01, t};
      v = 8'($urandom);
      prep('{`BAS_OP_LONG_JUMP, p[15:8], p[7:0]});
      put(p, '{{t[10:8], (i[0] ? `BAS_ABS_CALL : `BAS_ABS_JMP)}, t[7:0], 8'h74, v, 8'h80, 8'hfe});
      put(x, '{8'h74, v, 8'h80, 8'hfe});
      if (i[0]) put(x, '{`BAS_OP_RET});
      run(i[0] ? p + 16'h0004 : x + 16'h0002, 1'b0);
      check("acc absolute", acc_out, v);
    end
    test_done();
  end
endmodule : tb
